// ### isocs_map.svh
`ifndef ISOCS_MAP_SVH
`define ISOCS_MAP_SVH

// ==========================================================
// Register offsets (4-bit word address)
`define ISOCS_ADDR_DES_ENABLE   4'hD
`define ISOCS_ADDR_COARSE_SKEW  4'hE
`define ISOCS_ADDR_FINE_SKEW    4'hF

// ==========================================================
// Reset values
`define ISOCS_RST_DES_ENABLE    16'h3FFF
`define ISOCS_RST_COARSE_SKEW   16'h07FF
`define ISOCS_RST_FINE_SKEW     16'h007F

// ==========================================================
// Field positions
`define ISOCS_DUAL_EDGE_BIT     15
`define ISOCS_AUTO_PHASE_BIT    14
`define ISOCS_INPUT_SEL_BIT     15
`define ISOCS_ADJ_DIR_BIT       14
`define ISOCS_COARSE_MSB        13
`define ISOCS_COARSE_LSB        11
`define ISOCS_FINE_MSB          15
`define ISOCS_FINE_LSB          7
`define ISOCS_OFS_SIGN_BIT      8

// ==========================================================
// Coarse delay step in picoseconds and in tenths of a picosecond; offset step in tenths of a code
`define ISOCS_COARSE_STEP_PS    20
`define ISOCS_COARSE_STEP_TPS   11'd200
`define ISOCS_OFS_STEP_TENTHS   13'd10

// ==========================================================
// Timing
`define ISOCS_MCLK_PERIOD_NS    25
`define ISOCS_OCLK_LATENCY_NS   100
`define ISOCS_OCLK_LAT_CYC      ((`ISOCS_OCLK_LATENCY_NS + `ISOCS_MCLK_PERIOD_NS - 1) / `ISOCS_MCLK_PERIOD_NS)
`define ISOCS_AUTO_STEP_CYC     5'd16

`endif

// ### isocs_pkg.sv
package isocs_pkg;

    // ==========================================================
    // Register write request carried across the link
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] data;
    } isocs_wr_req_t;

    // ==========================================================
    // Per-channel sample clock delay setting
    typedef struct packed {
        logic [2:0]  coarse;
        logic [8:0]  fine;
    } isocs_delay_t;

    // ==========================================================
    // Output data clock sequencer, one-hot
    typedef enum logic [2:0] {
        OCK_RUN  = 3'b001,
        OCK_HOLD = 3'b010,
        OCK_WAIT = 3'b100
    } isocs_ock_state_t;

endpackage

// ### isocs_sysctl_model.sv
`timescale 1ns/1ps

module isocs_sysctl_model (
    // Sampling clock and calibration status
    input  wire logic       mclk_i,
    input  wire logic       cal_running_i,
    // Pulse request from the bench
    input  wire logic       go_i,
    input  wire logic [3:0] hold_cyc_i,
    // Output clock reset pin
    output logic            out_clk_reset_o
);
    // ==========================================================
    // Pulse sequencer
    initial begin
        out_clk_reset_o = 1'b0;
        forever begin
            @(posedge mclk_i);
            if (go_i) begin
                for (int k = 0; k < 64 && cal_running_i; k++) begin
                    @(posedge mclk_i);
                end
                // Off the sampling edge on purpose
                #7;
                out_clk_reset_o = 1'b1;
                repeat (hold_cyc_i) @(posedge mclk_i);
                #1;
                out_clk_reset_o = 1'b0;
            end
        end
    end
endmodule

// ### isocs_top.sv
`timescale 1ns/1ps
`include "isocs_map.svh"

module isocs_top
    import isocs_pkg::*;
(
    // Clocks and reset
    input  wire logic        MCLK_I,
    input  wire logic        LINK_CLK_I,
    input  wire logic        RESET_N_I,
    // Register write link, link clock domain
    input  wire logic        LINK_WR_I,
    input  wire logic [3:0]  LINK_ADDR_I,
    input  wire logic [15:0] LINK_DATA_I,
    output logic             LINK_READY_O,
    // Asynchronous pins
    input  wire logic        OUT_CLK_RESET_I,
    input  wire logic        DDR_MODE_I,
    input  wire logic        OUT_EDGE_I,
    input  wire logic        PHASE_LATE_I,
    input  wire logic        CAL_RUNNING_I,
    // Offset adjust codes, sign-magnitude
    input  wire logic [8:0]  OFFSET_I_CODE_I,
    input  wire logic [8:0]  OFFSET_Q_CODE_I,
    // Offset trims, tenths of a code
    output logic [12:0]      OFFSET_I_TRIM_O,
    output logic [12:0]      OFFSET_Q_TRIM_O,
    // Input routing and mode
    output logic             I_ADC_SRC_Q_O,
    output logic             Q_ADC_SRC_Q_O,
    output logic             INTERLEAVE_O,
    output logic             AUTO_PHASE_O,
    // Sample clock delays
    output logic [2:0]       I_COARSE_O,
    output logic [8:0]       I_FINE_O,
    output logic [2:0]       Q_COARSE_O,
    output logic [8:0]       Q_FINE_O,
    output logic [10:0]      I_DELAY_TPS_O,
    output logic [10:0]      Q_DELAY_TPS_O,
    // Output data clock
    output logic             OUT_DATA_CLK_O,
    output logic             OUT_CLK_ALIGNED_O,
    output logic             CAL_RESET_CLASH_O
);

    // ==========================================================
    // Functions
    function automatic logic [10:0] delay_tps(input isocs_delay_t d);
        logic [10:0] c;
        c = 11'(d.coarse) * `ISOCS_COARSE_STEP_TPS;
        return c + 11'(d.fine);
    endfunction

    // Negative zero sits one tenth below positive zero
    function automatic logic [12:0] offset_trim(input logic [8:0] code);
        logic [12:0] m;
        m = 13'(code[7:0]) * `ISOCS_OFS_STEP_TENTHS;
        if (code[`ISOCS_OFS_SIGN_BIT]) begin
            return 13'(~m);
        end
        return m;
    endfunction

    // ==========================================================
    // Register write crossing
    isocs_wr_req_t link_req;
    isocs_wr_req_t wr_req;
    logic          wr_stb;

    assign link_req = '{addr: LINK_ADDR_I, data: LINK_DATA_I};

    isocs_wr_cdc u_wr_cdc (
        .link_clk_i (LINK_CLK_I),
        .sys_clk_i  (MCLK_I),
        .reset_n_i  (RESET_N_I),
        .wr_i       (LINK_WR_I),
        .req_i      (link_req),
        .ready_o    (LINK_READY_O),
        .wr_o       (wr_stb),
        .req_o      (wr_req)
    );

    // ==========================================================
    // Configuration words, write-only
    logic [15:0] des_enable_q;
    logic [15:0] coarse_skew_q;
    logic [15:0] fine_skew_q;

    wire wr_des    = wr_stb && (wr_req.addr == `ISOCS_ADDR_DES_ENABLE);
    wire wr_coarse = wr_stb && (wr_req.addr == `ISOCS_ADDR_COARSE_SKEW);
    wire wr_fine   = wr_stb && (wr_req.addr == `ISOCS_ADDR_FINE_SKEW);

    // Low filler bits are stored but steer nothing
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            des_enable_q  <= `ISOCS_RST_DES_ENABLE;
            coarse_skew_q <= `ISOCS_RST_COARSE_SKEW;
            fine_skew_q   <= `ISOCS_RST_FINE_SKEW;
        end else begin
            if (wr_des) begin
                des_enable_q <= wr_req.data;
            end
            if (wr_coarse) begin
                coarse_skew_q <= wr_req.data;
            end
            if (wr_fine) begin
                fine_skew_q <= wr_req.data;
            end
        end
    end

    wire          dual_edge_en  = des_enable_q[`ISOCS_DUAL_EDGE_BIT];
    wire          auto_phase_en = des_enable_q[`ISOCS_AUTO_PHASE_BIT];
    wire          input_select  = coarse_skew_q[`ISOCS_INPUT_SEL_BIT];
    wire          adjust_dir    = coarse_skew_q[`ISOCS_ADJ_DIR_BIT];
    isocs_delay_t manual_delay;

    assign manual_delay.coarse = coarse_skew_q[`ISOCS_COARSE_MSB:`ISOCS_COARSE_LSB];
    assign manual_delay.fine   = fine_skew_q[`ISOCS_FINE_MSB:`ISOCS_FINE_LSB];

    // ==========================================================
    // Pin synchronisers
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    wire  [4:0] pin_raw = {CAL_RUNNING_I, PHASE_LATE_I, OUT_EDGE_I, DDR_MODE_I, OUT_CLK_RESET_I};

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pin_meta_q <= 5'h00;
            pin_sync_q <= 5'h00;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    wire ock_reset  = pin_sync_q[0];
    wire ddr_mode   = pin_sync_q[1];
    wire out_edge   = pin_sync_q[2];
    wire phase_late = pin_sync_q[3];
    wire cal_run    = pin_sync_q[4];

    // ==========================================================
    // Automatic phase control
    logic [4:0] auto_tick_q;
    logic [8:0] auto_trim_q;
    wire        auto_tick = (auto_tick_q == `ISOCS_AUTO_STEP_CYC - 5'd1);

    // Slow loop; the detector output is only looked at once per tick
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            auto_tick_q <= 5'h00;
            auto_trim_q <= 9'h000;
        end else if (!auto_phase_en || !dual_edge_en) begin
            auto_tick_q <= 5'h00;
            auto_trim_q <= 9'h000;
        end else begin
            auto_tick_q <= auto_tick ? 5'h00 : auto_tick_q + 5'd1;
            if (auto_tick && phase_late && auto_trim_q != 9'h1FF) begin
                auto_trim_q <= auto_trim_q + 9'd1;
            end else if (auto_tick && !phase_late && auto_trim_q != 9'h000) begin
                auto_trim_q <= auto_trim_q - 9'd1;
            end
        end
    end

    // ==========================================================
    // Delay steering
    isocs_delay_t zero_delay;
    isocs_delay_t auto_delay;
    isocs_delay_t i_delay;
    isocs_delay_t q_delay;

    assign zero_delay = '0;
    assign auto_delay = '{coarse: 3'h0, fine: auto_trim_q};
    // Manual settings bypassed when automatic phase runs
    assign i_delay = auto_phase_en ? zero_delay :
                     (adjust_dir ? zero_delay : manual_delay);
    assign q_delay = auto_phase_en ? auto_delay :
                     (adjust_dir ? manual_delay : zero_delay);

    // ==========================================================
    // Registered control outputs
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            I_COARSE_O      <= 3'h0;
            I_FINE_O        <= 9'h000;
            Q_COARSE_O      <= 3'h0;
            Q_FINE_O        <= 9'h000;
            I_DELAY_TPS_O   <= 11'h000;
            Q_DELAY_TPS_O   <= 11'h000;
            I_ADC_SRC_Q_O   <= 1'b0;
            Q_ADC_SRC_Q_O   <= 1'b1;
            INTERLEAVE_O    <= 1'b0;
            AUTO_PHASE_O    <= 1'b0;
            OFFSET_I_TRIM_O <= 13'h0000;
            OFFSET_Q_TRIM_O <= 13'h0000;
        end else begin
            I_COARSE_O      <= i_delay.coarse;
            I_FINE_O        <= i_delay.fine;
            Q_COARSE_O      <= q_delay.coarse;
            Q_FINE_O        <= q_delay.fine;
            I_DELAY_TPS_O   <= delay_tps(i_delay);
            Q_DELAY_TPS_O   <= delay_tps(q_delay);
            I_ADC_SRC_Q_O   <= dual_edge_en & input_select;
            Q_ADC_SRC_Q_O   <= dual_edge_en ? input_select : 1'b1;
            INTERLEAVE_O    <= dual_edge_en;
            AUTO_PHASE_O    <= auto_phase_en;
            OFFSET_I_TRIM_O <= offset_trim(OFFSET_I_CODE_I);
            OFFSET_Q_TRIM_O <= offset_trim(OFFSET_Q_CODE_I);
        end
    end

    // ==========================================================
    // Output data clock sequencer
    isocs_ock_state_t ock_state_q;
    isocs_ock_state_t ock_state_d;
    logic [3:0]       lat_cnt_q;
    logic [1:0]       div_cnt_q;
    logic             oclk_q;
    logic             aligned_q;
    logic             clash_q;

    // Parked level: follows out_edge in DDR, inverted out_edge in SDR
    wire       hold_level = ddr_mode ? out_edge : ~out_edge;
    wire [1:0] div_last   = ddr_mode ? 2'd1 : 2'd0;
    wire       lat_done   = (lat_cnt_q == 4'(`ISOCS_OCLK_LAT_CYC - 1));

    always_comb begin
        ock_state_d = ock_state_q;
        case (ock_state_q)
            OCK_RUN: begin
                if (ock_reset) begin
                    ock_state_d = OCK_HOLD;
                end
            end
            OCK_HOLD: begin
                if (!ock_reset) begin
                    ock_state_d = OCK_WAIT;
                end
            end
            OCK_WAIT: begin
                if (ock_reset) begin
                    ock_state_d = OCK_HOLD;
                end else if (lat_done) begin
                    ock_state_d = OCK_RUN;
                end
            end
            default: begin
                ock_state_d = OCK_HOLD;
            end
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ock_state_q <= OCK_RUN;
        end else begin
            ock_state_q <= ock_state_d;
        end
    end

    // Counters restart on release so every device lands on the same phase
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            lat_cnt_q <= 4'h0;
            div_cnt_q <= 2'h0;
        end else begin
            lat_cnt_q <= (ock_state_q == OCK_WAIT) ? lat_cnt_q + 4'd1 : 4'h0;
            if (ock_state_q != OCK_RUN || div_cnt_q == div_last) begin
                div_cnt_q <= 2'h0;
            end else begin
                div_cnt_q <= div_cnt_q + 2'd1;
            end
        end
    end

    // A running phase is cut short when reset lands mid-period
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            oclk_q    <= 1'b0;
            aligned_q <= 1'b0;
        end else begin
            aligned_q <= (ock_state_q == OCK_WAIT) && lat_done && !ock_reset;
            if (ock_state_q != OCK_RUN) begin
                oclk_q <= hold_level;
            end else if (div_cnt_q == div_last) begin
                oclk_q <= ~oclk_q;
            end
        end
    end

    // Flags a reset seen while calibration is running
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            clash_q <= 1'b0;
        end else if (ock_reset && cal_run) begin
            clash_q <= 1'b1;
        end else if (wr_des) begin
            clash_q <= 1'b0;
        end
    end

    assign OUT_DATA_CLK_O    = oclk_q;
    assign OUT_CLK_ALIGNED_O = aligned_q;
    assign CAL_RESET_CLASH_O = clash_q;

    // Alignment happens on the rising sampling edge only; a falling-edge
    // retime belongs to the analog output stage outside this block.

endmodule

// ### isocs_top_bench.sv
`timescale 1ns/1ps

module isocs_top_bench;
    // ==========================================================
    // Signals
    logic        mclk, lclk, rst_n, wr, ready, ocr, go, ddr, oedge, late, cal;
    logic        i_src, q_src, ilv, auto_ph, output_data_clock, aligned, clash, prev;
    logic [3:0]  addr;
    logic [15:0] data, want, tps;
    logic [8:0]  ocode_i, ocode_q, ifn, qfn;
    logic [12:0] trim_i, trim_q;
    logic [2:0]  ic, qc;
    logic [10:0] itps, qtps;
    int          err_count, n_compared, n, t;
    logic [2:0]  cv [4] = '{3'h0, 3'h7, 3'h5, 3'h1};
    logic [8:0]  fv [4] = '{9'h000, 9'h1FF, 9'h000, 9'h100};
    logic [8:0]  codes [5] = '{9'h000, 9'h100, 9'h005, 9'h105, 9'h0FF};

    isocs_top dut (
        .MCLK_I(mclk), .LINK_CLK_I(lclk), .RESET_N_I(rst_n), .LINK_WR_I(wr), .LINK_ADDR_I(addr),
        .LINK_DATA_I(data), .LINK_READY_O(ready), .OUT_CLK_RESET_I(ocr), .DDR_MODE_I(ddr),
        .OUT_EDGE_I(oedge), .PHASE_LATE_I(late), .CAL_RUNNING_I(cal), .OFFSET_I_CODE_I(ocode_i),
        .OFFSET_Q_CODE_I(ocode_q), .OFFSET_I_TRIM_O(trim_i), .OFFSET_Q_TRIM_O(trim_q),
        .I_ADC_SRC_Q_O(i_src), .Q_ADC_SRC_Q_O(q_src), .INTERLEAVE_O(ilv), .AUTO_PHASE_O(auto_ph),
        .I_COARSE_O(ic), .I_FINE_O(ifn), .Q_COARSE_O(qc), .Q_FINE_O(qfn), .I_DELAY_TPS_O(itps),
        .Q_DELAY_TPS_O(qtps), .OUT_DATA_CLK_O(output_data_clock), .OUT_CLK_ALIGNED_O(aligned),
        .CAL_RESET_CLASH_O(clash)
    );
    isocs_sysctl_model ctrl (
        .mclk_i(mclk), .cal_running_i(cal), .go_i(go), .hold_cyc_i(4'h8), .out_clk_reset_o(ocr)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Link clock offset so its edges drift against the sampling clock
    initial begin
        lclk = 1'b0;
        #4.3;
        forever #7.5 lclk = ~lclk;
    end

    // ==========================================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp_v, input string what);
        n_compared++;
        if (seen !== exp_v) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp_v);
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic step();
        @(posedge mclk);
        #2;
    endtask
    task automatic link_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge lclk);
        #1;
        wr = 1'b1;
        addr = a;
        data = d;
        for (n = 0; n < 100 && ready !== 1'b1; n++) begin
            @(posedge lclk);
            #1;
        end
        if (n == 100) begin
            check(16'h0000, 16'h0001, "link ready timeout");
            report_and_stop();
        end
        @(posedge lclk);
        #1;
        wr = 1'b0;
        for (n = 0; n < 200 && ready !== 1'b1; n++) begin
            @(posedge lclk);
            #1;
        end
        if (n == 200) begin
            check(16'h0000, 16'h0001, "link ready timeout");
            report_and_stop();
        end
        repeat (4) step();
    endtask
    task automatic wait_ocr(input logic lvl);
        for (n = 0; n < 64 && ocr !== lvl; n++) step();
        if (n == 64) begin
            check(16'h0000, 16'h0001, "reset pin timeout");
            report_and_stop();
        end
    endtask
    function automatic logic [12:0] trim_of(input logic [8:0] c);
        trim_of = c[8] ? ~(13'(c[7:0]) * 13'h000A) : 13'(c[7:0]) * 13'h000A;
    endfunction

    // ==========================================================
    // Sequence
    initial begin
        {rst_n, wr, go, ddr, oedge, late, cal} = '0;
        addr = 4'h0;
        data = 16'h0000;
        ocode_i = 9'h000;
        ocode_q = 9'h000;
        err_count = 0;
        n_compared = 0;
        repeat (12) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        step();
        check({1'b0, ic, ifn, qc}, 16'h0000, "delay after reset");
        check(16'(qfn), 16'h0000, "q fine after reset");
        check(16'({ilv, i_src, q_src}), 16'h0001, "plain routing");
        link_write(4'hD, 16'hBFFF);
        check(16'({ilv, auto_ph}), 16'h0002, "dual edge on");
        // Low bits written as ones, as software must
        for (int i = 0; i < 4; i++) begin
            link_write(4'hE, {i[1], i[0], cv[i], 11'h7FF});
            link_write(4'hF, {fv[i], 7'h7F});
            want = {4'h0, cv[i], fv[i]};
            tps = 16'(cv[i]) * 16'h00C8 + 16'(fv[i]);
            check(16'({i_src, q_src}), 16'({i[1], i[1]}), "input select");
            check({4'h0, ic, ifn}, i[0] ? 16'h0000 : want, "i delay");
            check({4'h0, qc, qfn}, i[0] ? want : 16'h0000, "q delay");
            check(16'(i[0] ? qtps : itps), tps, "delay total");
        end
        link_write(4'h3, 16'h0000);
        check({4'h0, qc, qfn}, want, "unmapped write");
        foreach (codes[k]) begin
            @(posedge mclk);
            #1;
            ocode_i = codes[k];
            ocode_q = codes[k] ^ 9'h100;
            repeat (3) step();
            check(16'(trim_i), 16'(trim_of(codes[k])), "trim i");
            check(16'(trim_q), 16'(trim_of(codes[k] ^ 9'h100)), "trim q");
        end
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk);
            #1;
            ddr = m[1];
            oedge = m[0];
            cal = (m == 3);
            go = 1'b1;
            @(posedge mclk);
            #1;
            go = 1'b0;
            if (m == 3) begin
                repeat (20) step();
                check(16'(ocr), 16'h0000, "pulse during calibration");
                cal = 1'b0;
            end
            wait_ocr(1'b1);
            repeat (5) step();
            check(16'(output_data_clock), 16'(m[1] ? m[0] : !m[0]), "hold level");
            wait_ocr(1'b0);
            for (t = 0; t < 20 && aligned !== 1'b1; t++) step();
            check(16'(t), 16'h0007, "restart latency");
            if (t == 20) report_and_stop();
            prev = output_data_clock;
            t = 0;
            repeat (8) begin
                step();
                if (output_data_clock !== prev) t++;
                prev = output_data_clock;
            end
            check(16'(t), m[1] ? 16'h0004 : 16'h0008, "toggle count");
        end
        check(16'(clash), 16'h0000, "calibration clash");
        link_write(4'hD, 16'hFFFF);
        @(posedge mclk);
        #1;
        late = 1'b1;
        repeat (40) step();
        check({auto_ph, ic, ifn, qc}, 16'h8000, "manual skew ignored");
        check(16'(qfn != 9'h000), 16'h0001, "phase trim moves");
        want = 16'(qfn);
        late = 1'b0;
        repeat (40) step();
        check(16'(qfn < want[8:0]), 16'h0001, "phase trim falls");
        report_and_stop();
    end
endmodule

// ### isocs_top_sva.sv
`timescale 1ns/1ps

module isocs_top_chk (
    // Clock and reset
    input wire logic        MCLK_I,
    input wire logic        RESET_N_I,
    // Pins
    input wire logic        OUT_CLK_RESET_I,
    input wire logic        DDR_MODE_I,
    input wire logic        OUT_EDGE_I,
    input wire logic [8:0]  OFFSET_I_CODE_I,
    // Observed outputs
    input wire logic [12:0] OFFSET_I_TRIM_O,
    input wire logic        I_ADC_SRC_Q_O,
    input wire logic        Q_ADC_SRC_Q_O,
    input wire logic        INTERLEAVE_O,
    input wire logic        AUTO_PHASE_O,
    input wire logic [2:0]  I_COARSE_O,
    input wire logic [8:0]  I_FINE_O,
    input wire logic [2:0]  Q_COARSE_O,
    input wire logic [8:0]  Q_FINE_O,
    input wire logic [10:0] I_DELAY_TPS_O,
    input wire logic [10:0] Q_DELAY_TPS_O,
    input wire logic        OUT_DATA_CLK_O,
    input wire logic        OUT_CLK_ALIGNED_O
);
    // ==========================================================
    // Expected trim, kept combinational so $past sees one value
    logic [12:0] trim_mag;
    logic [12:0] trim_exp;
    assign trim_mag = {5'h00, OFFSET_I_CODE_I[7:0]} * 13'h000A;
    assign trim_exp = OFFSET_I_CODE_I[8] ? ~trim_mag : trim_mag;

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    // ==========================================================
    // Properties
    reset_zero_a: assert property ($rose(RESET_N_I) |->
        I_DELAY_TPS_O == 11'h000 && Q_DELAY_TPS_O == 11'h000 && !INTERLEAVE_O && !AUTO_PHASE_O)
        else $error("skew outputs not zero after reset");
    plain_route_a: assert property (!INTERLEAVE_O |-> !I_ADC_SRC_Q_O && Q_ADC_SRC_Q_O)
        else $error("independent channels not on own inputs");
    same_input_a: assert property (INTERLEAVE_O |-> I_ADC_SRC_Q_O == Q_ADC_SRC_Q_O)
        else $error("interleaved converters on different inputs");
    one_side_a: assert property (!AUTO_PHASE_O |->
        {I_COARSE_O, I_FINE_O} == 12'h000 || {Q_COARSE_O, Q_FINE_O} == 12'h000)
        else $error("both sample clocks delayed");
    delay_sum_a: assert property (
        I_DELAY_TPS_O == {8'h00, I_COARSE_O} * 11'h0C8 + {2'h0, I_FINE_O} &&
        Q_DELAY_TPS_O == {8'h00, Q_COARSE_O} * 11'h0C8 + {2'h0, Q_FINE_O})
        else $error("delay total does not match codes");
    trim_sign_a: assert property (1'b1 |=> OFFSET_I_TRIM_O == $past(trim_exp))
        else $error("offset trim wrong for sign and magnitude");
    hold_level_a: assert property (OUT_CLK_RESET_I [*6] |->
        OUT_DATA_CLK_O == (DDR_MODE_I ? OUT_EDGE_I : !OUT_EDGE_I))
        else $error("output clock not at hold level");
    align_lat_a: assert property ($fell(OUT_CLK_RESET_I) && $past(OUT_CLK_RESET_I, 4) |->
        !OUT_CLK_ALIGNED_O [*7] ##1 OUT_CLK_ALIGNED_O)
        else $error("output clock restart latency wrong");
    sdr_resume_a: assert property (OUT_CLK_ALIGNED_O && !DDR_MODE_I |->
        ##2 $changed(OUT_DATA_CLK_O) [*4])
        else $error("output clock not toggling after restart");
    auto_ignore_a: assert property (AUTO_PHASE_O && INTERLEAVE_O |->
        I_COARSE_O == 3'h0 && I_FINE_O == 9'h000 && Q_COARSE_O == 3'h0)
        else $error("manual skew applied under automatic phase");

    cover property (OUT_CLK_ALIGNED_O && DDR_MODE_I);
    cover property (INTERLEAVE_O && I_ADC_SRC_Q_O);
    cover property (AUTO_PHASE_O && Q_FINE_O != 9'h000);
endmodule

bind isocs_top isocs_top_chk u_chk (
    .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .OUT_CLK_RESET_I(OUT_CLK_RESET_I),
    .DDR_MODE_I(DDR_MODE_I), .OUT_EDGE_I(OUT_EDGE_I), .OFFSET_I_CODE_I(OFFSET_I_CODE_I),
    .OFFSET_I_TRIM_O(OFFSET_I_TRIM_O), .I_ADC_SRC_Q_O(I_ADC_SRC_Q_O), .Q_ADC_SRC_Q_O(Q_ADC_SRC_Q_O),
    .INTERLEAVE_O(INTERLEAVE_O), .AUTO_PHASE_O(AUTO_PHASE_O), .I_COARSE_O(I_COARSE_O),
    .I_FINE_O(I_FINE_O), .Q_COARSE_O(Q_COARSE_O), .Q_FINE_O(Q_FINE_O),
    .I_DELAY_TPS_O(I_DELAY_TPS_O), .Q_DELAY_TPS_O(Q_DELAY_TPS_O),
    .OUT_DATA_CLK_O(OUT_DATA_CLK_O), .OUT_CLK_ALIGNED_O(OUT_CLK_ALIGNED_O)
);

// ### isocs_wr_cdc.sv
`timescale 1ns/1ps

module isocs_wr_cdc
    import isocs_pkg::*;
(
    // Clocks and reset
    input  wire logic          link_clk_i,
    input  wire logic          sys_clk_i,
    input  wire logic          reset_n_i,
    // Link side
    input  wire logic          wr_i,
    input  wire isocs_wr_req_t req_i,
    output logic               ready_o,
    // System side
    output logic               wr_o,
    output isocs_wr_req_t      req_o
);

    // ==========================================================
    // Link domain: hold word, toggle request
    logic          req_tgl_q;
    logic          ack_meta_q;
    logic          ack_sync_q;
    isocs_wr_req_t hold_q;
    logic          ack_tgl_q;
    wire           busy = req_tgl_q ^ ack_sync_q;

    assign ready_o = ~busy;

    always_ff @(posedge link_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_tgl_q  <= 1'b0;
            ack_meta_q <= 1'b0;
            ack_sync_q <= 1'b0;
            hold_q     <= '0;
        end else begin
            ack_meta_q <= ack_tgl_q;
            ack_sync_q <= ack_meta_q;
            // Word stays still until the far side acknowledges
            if (wr_i && !busy) begin
                hold_q    <= req_i;
                req_tgl_q <= ~req_tgl_q;
            end
        end
    end

    // ==========================================================
    // System domain: detect toggle, sample held word
    logic req_meta_q;
    logic req_sync_q;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_meta_q <= 1'b0;
            req_sync_q <= 1'b0;
            ack_tgl_q  <= 1'b0;
            wr_o       <= 1'b0;
            req_o      <= '0;
        end else begin
            req_meta_q <= req_tgl_q;
            req_sync_q <= req_meta_q;
            ack_tgl_q  <= req_sync_q;
            wr_o       <= req_sync_q ^ ack_tgl_q;
            if (req_sync_q ^ ack_tgl_q) begin
                req_o <= hold_q;
            end
        end
    end

endmodule
